// ### core/scs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "scs_map.svh"
// Function
// - receive-command-steps collects command bytes, length from first byte
// - unknown group loads start count with five, clears group valid
// - known group loads matching length and sets group valid
// - atn during receive sets service request and clears command
// - parity error ends receive early and clears command
// - dma stop runs at once, drops queued command with illegal-op error
// - when stop conditions hold, halt and raise dma request
// - dma stop resets dma request, finishes per sync/async, send/receive
// - access fifo after abort lets dma read leftovers, normal mode only
// - pair drain on: request while two or more bytes remain
// - pair drain off: request while fifo not empty
// - idle commands while connected are rejected as invalid, command cleared
// - reselect arbitrates, sends identify, ends on timeout, clears step state
// - select without atn sends cdb, ends early on phase faults
// - select with atn sends one message byte then cdb
// - select with atn and stop sends one byte, halts with atn held
// - atn held until transfer counter reaches zero after next command
// - disconnect disables selection response; enable command re-arms it
module scs_sequencer
  import scs_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       cmd_wr,
  input  wire logic [7:0] cmd_code,
  input  wire logic       int_clear,
  input  wire logic       status_clear,
  input  wire logic       scsi_atn_n,
  input  wire logic [2:0] scsi_phase,
  input  wire logic       target_mode,
  input  wire logic       connected,
  input  wire logic       bus_free,
  input  wire logic       normal_dma_mode,
  input  wire logic       pair_drain_mode,
  input  wire logic       rx_byte_valid,
  input  wire logic [7:0] rx_byte,
  input  wire logic       parity_err,
  input  wire logic       arb_won,
  input  wire logic       sel_timeout,
  input  wire logic       sel_done,
  input  wire logic       tx_byte_done,
  input  wire logic       xfer_done,
  input  wire logic       dma_xfer_active,
  input  wire logic       dma_xfer_send,
  input  wire logic       dma_xfer_sync,
  input  wire logic       dma_abort_seen,
  input  wire logic [4:0] fifo_count_field,
  input  wire logic       count_zero_flag,
  input  wire logic       sync_offset_max,
  input  wire logic       acks_outstanding_zero,
  output logic [7:0]      command_reg,
  output logic [7:0]      start_count_reg,
  output logic            group_code_valid,
  output logic            illegal_op_error,
  output logic [3:0]      interrupt_status_reg,
  output logic            dma_request,
  output logic            dma_if_reset,
  output logic            halted,
  output logic            arb_request,
  output logic            atn_out,
  output logic            xfer_go,
  output logic            selresel_enable,
  output logic            rx_to_dma,
  output logic [2:0]      sequence_state_reg
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam logic [3:0] PIN_RST = `SCS_PIN_RST;
  logic [3:0] sync_a_reg;
  logic [3:0] sync_b_reg;
  wire  [3:0] pin_in = {scsi_atn_n, scsi_phase};

  // atn and phase come straight off the cable
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        sync_a_reg[i] <= PIN_RST[i];
        sync_b_reg[i] <= PIN_RST[i];
      end else begin
        sync_a_reg[i] <= pin_in[i];
        sync_b_reg[i] <= sync_a_reg[i];
      end
    end
  end

  wire       atn_s   = !sync_b_reg[3];
  wire [2:0] phase_s = sync_b_reg[2:0];
  wire       ph_cmd  = (phase_s == `SCS_PH_CMD);
  wire       ph_mout = (phase_s == `SCS_PH_MSGOUT);

  // ****************************************
  // state and queue registers
  // ****************************************
  scs_state_t state_reg, state_next;
  logic       pend_v_reg, pend_v_next;
  logic [7:0] pend_code_reg, pend_code_next;
  logic       abort_reg, abort_next;
  logic [7:0] rcnt_reg, rcnt_next;
  logic       hold_reg, hold_next;
  logic       armed_reg, armed_next;
  logic [7:0] command_next, start_next;
  logic       gcv_next, ioe_next, dma_request_next, difr_next, halt_next;
  logic       arb_next, atn_next, go_next, sre_next, rxd_next;
  logic [3:0] int_next, int_set;
  logic [2:0] seq_next;
  logic       ioe_set;

  // ****************************************
  // command decode
  // ****************************************
  wire        dstop_wr = cmd_wr && (cmd_code[6:0] == `SCS_OP_DSTOP);
  wire        new_wr   = cmd_wr && !dstop_wr;
  wire        launch   = (state_reg == S_IDLE) && (pend_v_reg || new_wr);
  wire [7:0]  l_code   = pend_v_reg ? pend_code_reg : cmd_code;
  wire [6:0]  l_op     = l_code[6:0];
  wire        l_rcv    = (l_op == `SCS_OP_RCVCMD);
  wire        l_afifo  = (l_op == `SCS_OP_AFIFO);
  wire        l_resel  = (l_op == `SCS_OP_RESEL);
  wire        l_ensel  = (l_op == `SCS_OP_ENSEL);
  wire        l_idle   = (l_op >= `SCS_OP_RESEL) && (l_op <= `SCS_OP_ENSEL);
  wire        l_selany = l_idle && !l_ensel;
  wire [6:0]  c_op     = command_reg[6:0];
  wire        c_resel  = (c_op == `SCS_OP_RESEL);
  wire        c_sel    = (c_op == `SCS_OP_SEL);
  wire        c_stop   = (c_op == `SCS_OP_SELSTOP);
  wire        c_atn    = (c_op == `SCS_OP_SELATN) || c_stop;

  // first command byte decides the block length
  wire [2:0]  grp     = rx_byte[`SCS_GRP_LSB +: 3];
  wire        grp_ok  = (grp == `SCS_GRP0) || (grp == `SCS_GRP1) ||
                        (grp == `SCS_GRP2) || (grp == `SCS_GRP5);
  wire [7:0]  len_w   = (grp == `SCS_GRP0) ? `SCS_LEN_G0 :
                        (grp == `SCS_GRP5) ? `SCS_LEN_G5 :
                        grp_ok ? `SCS_LEN_G12 : `SCS_LEN_UNK;
  wire [7:0]  rcnt_p1 = rcnt_reg + 8'h01;
  wire [7:0]  rlen    = (rcnt_reg == 8'h00) ? len_w : start_count_reg;

  // stop readiness per transfer flavour
  wire fifo_full  = (fifo_count_field == `SCS_FIFO_FULL);
  wire fifo_empty = (fifo_count_field == `SCS_FIFO_NONE);
  wire stop_ready = dma_xfer_send ? fifo_empty :
                    dma_xfer_sync ? (count_zero_flag || sync_offset_max) :
                    (fifo_full || count_zero_flag);
  wire dstop_fin  = !dma_xfer_sync ||
                    (dma_xfer_send ? count_zero_flag : acks_outstanding_zero);
  wire afifo_want = pair_drain_mode ? (fifo_count_field >= `SCS_FIFO_PAIR)
                                    : !fifo_empty;

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    state_next     = state_reg;
    pend_v_next    = pend_v_reg;
    pend_code_next = pend_code_reg;
    abort_next     = abort_reg || dma_abort_seen;
    rcnt_next      = rcnt_reg;
    hold_next      = hold_reg;
    armed_next     = armed_reg;
    command_next   = command_reg;
    start_next     = start_count_reg;
    gcv_next       = group_code_valid;
    arb_next       = arb_request;
    atn_next       = atn_out;
    go_next        = xfer_go;
    sre_next       = selresel_enable;
    rxd_next       = rx_to_dma;
    seq_next       = sequence_state_reg;
    dma_request_next      = dma_request;
    halt_next      = halted;
    difr_next      = 1'b0;
    int_set        = 4'h0;
    ioe_set        = 1'b0;
    // one-deep queue; a command waits while a sequence runs
    if (launch && pend_v_reg) begin
      pend_v_next = 1'b0;
    end
    if (new_wr && ((state_reg != S_IDLE) || pend_v_reg)) begin
      pend_v_next    = 1'b1;
      pend_code_next = cmd_code;
    end
    // atn kept after select-and-stop until the counter drains
    if (hold_reg && cmd_wr) begin
      armed_next = 1'b1;
    end
    if (hold_reg && armed_reg && count_zero_flag) begin
      hold_next  = 1'b0;
      armed_next = 1'b0;
      atn_next   = 1'b0;
    end
    unique case (state_reg)
      S_IDLE: begin
        dma_request_next = dma_xfer_active && stop_ready;
        halt_next = dma_xfer_active && stop_ready;
        if (launch) begin
          command_next = l_code;
          if (l_idle && connected) begin
            int_set[`SCS_INT_INV] = 1'b1;
            command_next          = 8'h00;
          end else if (l_rcv) begin
            if (target_mode && connected) begin
              state_next = S_RCV;
              rcnt_next  = 8'h00;
            end else begin
              int_set[`SCS_INT_INV] = 1'b1;
              command_next          = 8'h00;
            end
          end else if (l_afifo) begin
            if (abort_reg && normal_dma_mode) begin
              state_next = S_AFIFO;
            end else begin
              int_set[`SCS_INT_INV] = 1'b1;
              command_next          = 8'h00;
            end
          end else if (l_ensel) begin
            sre_next = 1'b1;
            rxd_next = l_code[`SCS_DMA_BIT];
          end else if (l_selany) begin
            state_next = S_ARB;
            arb_next   = 1'b1;
            if (l_resel) begin
              seq_next = 3'h0;
            end
          end
        end
      end
      S_RCV: begin
        if (atn_s) begin
          int_set[`SCS_INT_SERV] = 1'b1;
          command_next           = 8'h00;
          state_next             = S_IDLE;
        end else if (parity_err) begin
          command_next = 8'h00;
          abort_next   = 1'b1;
          state_next   = S_IDLE;
        end else if (rx_byte_valid && ph_cmd) begin
          rcnt_next = rcnt_p1;
          if (rcnt_reg == 8'h00) begin
            start_next = len_w;
            gcv_next   = grp_ok;
          end
          if (rcnt_p1 == rlen) begin
            int_set[`SCS_INT_SUCC] = 1'b1;
            state_next             = S_IDLE;
          end
        end
      end
      S_DSTOP: begin
        if (dstop_fin) begin
          int_set[`SCS_INT_SUCC] = 1'b1;
          state_next             = S_IDLE;
        end
      end
      S_AFIFO: begin
        dma_request_next = afifo_want;
        if (!afifo_want) begin
          abort_next = dma_abort_seen; // a fresh abort outlives the drain
          state_next = S_IDLE;
        end
      end
      S_ARB: begin
        if (sel_timeout) begin
          int_set[`SCS_INT_DISC] = 1'b1;
          arb_next               = 1'b0;
          state_next             = S_IDLE;
        end else if (arb_won) begin
          arb_next   = 1'b0;
          atn_next   = c_atn;
          seq_next   = sequence_state_reg + 3'h1;
          state_next = S_SEL;
        end
      end
      S_SEL: begin
        if (sel_timeout) begin
          int_set[`SCS_INT_DISC] = 1'b1;
          atn_next               = 1'b0;
          state_next             = S_IDLE;
        end else if (sel_done) begin
          seq_next = sequence_state_reg + 3'h1;
          if (c_resel || (c_atn && ph_mout)) begin
            state_next = S_MSG;
          end else if (c_sel && ph_cmd) begin
            state_next = S_CMD;
          end else begin
            int_set[`SCS_INT_SERV] = 1'b1;
            atn_next               = 1'b0;
            state_next             = S_IDLE;
          end
        end
      end
      S_MSG: begin
        go_next = 1'b1;
        if (!c_resel && !ph_mout) begin
          int_set[`SCS_INT_SERV] = 1'b1;
          go_next                = 1'b0;
          atn_next               = 1'b0;
          state_next             = S_IDLE;
        end else if (tx_byte_done) begin
          go_next  = 1'b0;
          seq_next = sequence_state_reg + 3'h1;
          if (c_resel || c_stop) begin
            int_set[`SCS_INT_SUCC] = 1'b1;
            hold_next              = c_stop;
            state_next             = S_IDLE;
          end else begin
            atn_next   = 1'b0;
            state_next = S_CMD;
          end
        end
      end
      S_CMD: begin
        if (ph_cmd) begin
          go_next = 1'b1;
          if (xfer_done) begin
            int_set[`SCS_INT_SUCC] = 1'b1;
            int_set[`SCS_INT_SERV] = !c_sel;
            go_next                = 1'b0;
            state_next             = S_IDLE;
          end
        end else if (xfer_go || !ph_mout) begin
          int_set[`SCS_INT_SERV] = 1'b1;
          go_next                = 1'b0;
          state_next             = S_IDLE;
        end
      end
    endcase
    // dma stop bypasses the queue in every state and is never stored
    if (dstop_wr) begin
      ioe_set     = pend_v_reg;
      pend_v_next = 1'b0;
      if ((state_reg == S_IDLE) && dma_xfer_active) begin
        state_next = S_DSTOP;
        dma_request_next  = 1'b0;
        halt_next  = 1'b0;
        difr_next  = 1'b1;
      end
    end
    // a disconnect turns the selection response off and drops atn
    if (bus_free) begin
      sre_next   = l_ensel && launch && !connected;
      atn_next   = 1'b0;
      hold_next  = 1'b0;
      armed_next = 1'b0;
    end
    // event bits are sticky; a set in the clearing cycle survives
    int_next = (interrupt_status_reg & ~{4{int_clear}}) | int_set;
    ioe_next = (illegal_op_error && !status_clear) || ioe_set;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg     <= S_IDLE;
      pend_v_reg    <= 1'b0;
      pend_code_reg <= 8'h00;
      abort_reg     <= 1'b0;
      rcnt_reg      <= 8'h00;
      hold_reg      <= 1'b0;
      armed_reg     <= 1'b0;
    end else begin
      state_reg     <= state_next;
      pend_v_reg    <= pend_v_next;
      pend_code_reg <= pend_code_next;
      abort_reg     <= abort_next;
      rcnt_reg      <= rcnt_next;
      hold_reg      <= hold_next;
      armed_reg     <= armed_next;
    end
  end

  // every output is a flop
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      command_reg          <= 8'h00;
      start_count_reg      <= 8'h00;
      group_code_valid     <= 1'b0;
      illegal_op_error     <= 1'b0;
      interrupt_status_reg <= 4'h0;
      dma_request          <= 1'b0;
      dma_if_reset         <= 1'b0;
      halted               <= 1'b0;
      arb_request          <= 1'b0;
      atn_out              <= 1'b0;
      xfer_go              <= 1'b0;
      selresel_enable      <= 1'b0;
      rx_to_dma            <= 1'b0;
      sequence_state_reg   <= 3'h0;
    end else begin
      command_reg          <= command_next;
      start_count_reg      <= start_next;
      group_code_valid     <= gcv_next;
      illegal_op_error     <= ioe_next;
      interrupt_status_reg <= int_next;
      dma_request          <= dma_request_next;
      dma_if_reset         <= difr_next;
      halted               <= halt_next;
      arb_request          <= arb_next;
      atn_out              <= atn_next;
      xfer_go              <= go_next;
      selresel_enable      <= sre_next;
      rx_to_dma            <= rxd_next;
      sequence_state_reg   <= seq_next;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  wire first_byte = (state_reg == S_RCV) && !atn_s && !parity_err &&
                    rx_byte_valid && ph_cmd && (rcnt_reg == 8'h00);

  sequence arb_atn_s;
    (state_reg == S_ARB) && !sel_timeout && arb_won && c_atn;
  endsequence
  sequence msg_stop_s;
    (state_reg == S_MSG) && c_stop && ph_mout && tx_byte_done;
  endsequence

  unk_len_a: assert property (first_byte && !grp_ok |=>
    start_count_reg == `SCS_LEN_UNK && !group_code_valid)
    else $error("unknown group did not load five");
  grp_len_a: assert property (first_byte && grp == `SCS_GRP0 |=>
    start_count_reg == `SCS_LEN_G0 && group_code_valid)
    else $error("group zero length wrong");
  rcv_atn_a: assert property ((state_reg == S_RCV) && atn_s |=>
    interrupt_status_reg[`SCS_INT_SERV] && command_reg == 8'h00 && state_reg == S_IDLE)
    else $error("atn did not end receive");
  rcv_parity_a: assert property ((state_reg == S_RCV) && !atn_s && parity_err |=>
    command_reg == 8'h00 && state_reg == S_IDLE)
    else $error("parity did not end receive");
  dstop_ioe_a: assert property (dstop_wr && pend_v_reg |=>
    illegal_op_error && !pend_v_reg)
    else $error("queued command survived dma stop");
  dstop_dma_request_a: assert property ((state_reg == S_IDLE) && dstop_wr && dma_xfer_active |=>
    !dma_request && dma_if_reset ##1 !dma_if_reset)
    else $error("dma stop did not reset request");
  afifo_pair_a: assert property ((state_reg == S_AFIFO) && pair_drain_mode |=>
    dma_request == ($past(fifo_count_field) >= `SCS_FIFO_PAIR))
    else $error("pair drain request wrong");
  afifo_any_a: assert property ((state_reg == S_AFIFO) && !pair_drain_mode |=>
    dma_request == ($past(fifo_count_field) != `SCS_FIFO_NONE))
    else $error("drain request wrong");
  idle_reject_a: assert property (launch && l_idle && connected |=>
    interrupt_status_reg[`SCS_INT_INV] && command_reg == 8'h00 && state_reg == S_IDLE)
    else $error("idle command accepted while connected");
  resel_seq_a: assert property (launch && l_resel && !connected |=>
    sequence_state_reg == 3'h0 && arb_request)
    else $error("reselect did not start cleanly");
  sel_atn_a: assert property (arb_atn_s |=> atn_out)
    else $error("atn not raised on selection");
  stop_hold_a: assert property (msg_stop_s and !bus_free |=>
    atn_out && state_reg == S_IDLE && interrupt_status_reg[`SCS_INT_SUCC])
    else $error("stop did not hold atn");
  disc_off_a: assert property (bus_free && !launch |=> !selresel_enable)
    else $error("disconnect left selection enabled");

endmodule : scs_sequencer
`default_nettype wire

// ### core/scs_map.svh
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH
// ****************************************
// command opcodes (low seven bits, bit 7 selects dma)
// ****************************************
`define SCS_DMA_BIT    7
`define SCS_OP_NOP     7'h00
`define SCS_OP_DSTOP   7'h04
`define SCS_OP_AFIFO   7'h05
`define SCS_OP_RCVCMD  7'h2B
`define SCS_OP_RESEL   7'h40
`define SCS_OP_SEL     7'h41
`define SCS_OP_SELATN  7'h42
`define SCS_OP_SELSTOP 7'h43
`define SCS_OP_ENSEL   7'h44
// ****************************************
// command block group codes and lengths
// ****************************************
`define SCS_GRP_LSB    5
`define SCS_GRP0       3'h0
`define SCS_GRP1       3'h1
`define SCS_GRP2       3'h2
`define SCS_GRP5       3'h5
`define SCS_LEN_G0     8'h06
`define SCS_LEN_G12    8'h0A
`define SCS_LEN_G5     8'h0C
`define SCS_LEN_UNK    8'h05
// ****************************************
// bus phases {msg, c/d, i/o}, fifo levels
// ****************************************
`define SCS_PH_CMD     3'h2
`define SCS_PH_MSGOUT  3'h6
`define SCS_FIFO_FULL  5'h10
`define SCS_FIFO_PAIR  5'h02
`define SCS_FIFO_NONE  5'h00
`define SCS_PIN_RST    4'h8
// ****************************************
// interrupt status bit positions
// ****************************************
`define SCS_INT_SUCC   0
`define SCS_INT_SERV   1
`define SCS_INT_INV    2
`define SCS_INT_DISC   3
`endif

// ### core/scs_pkg.sv
package scs_pkg;
  // sequencer states, one-hot
  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,
    S_RCV   = 8'h02,
    S_DSTOP = 8'h04,
    S_AFIFO = 8'h08,
    S_ARB   = 8'h10,
    S_SEL   = 8'h20,
    S_MSG   = 8'h40,
    S_CMD   = 8'h80
  } scs_state_t;
endpackage : scs_pkg

// ### tb/scs_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// initiator on the far side of the bus
// ****************************************
module scs_bus_model (
  input  wire logic       clock,
  input  wire logic       send,
  input  wire logic [7:0] data,
  input  wire logic       atn,
  input  wire logic [2:0] phase,
  output logic [2:0]      scsi_phase,
  output logic            scsi_atn_n,
  output logic            rx_byte_valid,
  output logic [7:0]      rx_byte
);
  // phase lines as the far side drives them; command phase by default
  assign scsi_phase = phase;
  assign scsi_atn_n = ~atn;
  // byte lasts one cycle; idle lines invert every cycle, so stale data matches on every second idle cycle
  always_ff @(posedge clock) begin
    rx_byte_valid <= send;
    rx_byte       <= send ? data : ~rx_byte;
  end
endmodule : scs_bus_model
`default_nettype wire

// ### tb/scs_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module scs_sequencer_tb;
  import scs_pkg::*;
  logic clock = 0, resetn = 0, cmd_wr = 0, int_clear = 0, status_clear = 0;
  logic target_mode = 1, connected = 1, bus_free = 0, normal_dma_mode = 1;
  logic pair_drain_mode = 0, parity_err = 0, arb_won = 0, sel_timeout = 0;
  logic sel_done = 0, tx_byte_done = 0, xfer_done = 0, dma_xfer_active = 0;
  logic dma_xfer_send = 0, dma_xfer_sync = 0, dma_abort_seen = 0, send = 0, atn = 0;
  logic count_zero_flag = 0, sync_offset_max = 0, acks_outstanding_zero = 0;
  logic [7:0] cmd_code = 8'h00, data = 8'h00, command_reg, start_count_reg, rx_byte;
  logic [4:0] fifo_count_field = 5'h00;
  logic [2:0] phase = 3'h2;
  logic [3:0] interrupt_status_reg;
  logic [2:0] scsi_phase, sequence_state_reg;
  logic scsi_atn_n, rx_byte_valid, group_code_valid, illegal_op_error, dma_request;
  logic dma_if_reset, halted, arb_request, atn_out, xfer_go, selresel_enable, rx_to_dma;
  logic [31:0] seed = 32'd30394;
  logic [7:0] b;
  logic [4:0] lv [4];
  int fail_count = 0, checked = 0, cycles = 0;

  // ****************************************
  // clock, design and far side
  // ****************************************
  always #4 clock = ~clock;
  scs_sequencer u_dut (.clock, .resetn, .cmd_wr, .cmd_code, .int_clear, .status_clear,
    .scsi_atn_n, .scsi_phase, .target_mode, .connected, .bus_free, .normal_dma_mode,
    .pair_drain_mode, .rx_byte_valid, .rx_byte, .parity_err, .arb_won, .sel_timeout,
    .sel_done, .tx_byte_done, .xfer_done, .dma_xfer_active, .dma_xfer_send,
    .dma_xfer_sync, .dma_abort_seen, .fifo_count_field, .count_zero_flag,
    .sync_offset_max, .acks_outstanding_zero, .command_reg, .start_count_reg,
    .group_code_valid, .illegal_op_error, .interrupt_status_reg, .dma_request,
    .dma_if_reset, .halted, .arb_request, .atn_out, .xfer_go, .selresel_enable,
    .rx_to_dma, .sequence_state_reg);
  scs_bus_model u_bus (.clock, .send, .data, .atn, .phase, .scsi_phase, .scsi_atn_n,
    .rx_byte_valid, .rx_byte);

  // ****************************************
  // helpers and reference model
  // ****************************************
  task automatic test_done();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // block length from the group field of the first byte
  function automatic logic [7:0] exp_len(input logic [7:0] v);
    case (v[7:5])
      3'h0: return 8'h06;
      3'h1, 3'h2: return 8'h0A;
      3'h5: return 8'h0C;
      default: return 8'h05;
    endcase
  endfunction : exp_len
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // extra edges after release let the pin synchronizers fill
  task automatic rst();
    resetn = 0;
    tick(2);
    resetn = 1;
    tick(3);
  endtask : rst
  task automatic cmd(input logic [7:0] c);
    cmd_wr = 1;
    cmd_code = c;
    tick(1);
    cmd_wr = 0;
  endtask : cmd
  task automatic pulse_byte(input logic [7:0] v);
    send = 1;
    data = v;
    tick(1);
    send = 0;
    tick(2);
  endtask : pulse_byte
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      test_done();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    tick(12);
    // every group code as first byte, random low bits
    for (int g = 0; g < 8; g++) begin
      rst();
      cmd(8'h2B);
      b = {g[2:0], 5'(rnd())};
      pulse_byte(b);
      chk("start_count", start_count_reg, exp_len(b));
      chk("gcv", 8'(group_code_valid), 8'(exp_len(b) != 8'h05));
    end
    // queued command dropped by dma stop, then atn during receive
    cmd_wr = 1;
    cmd_code = 8'h40;
    tick(1);
    cmd_code = 8'h84;
    tick(1);
    cmd_wr = 0;
    tick(1);
    chk("ioe", 8'(illegal_op_error), 8'h01);
    atn = 1;
    tick(5);
    chk("serv", 8'(interrupt_status_reg[1]), 8'h01);
    chk("cmd_atn", command_reg, 8'h00);
    atn = 0;
    // idle commands while connected are refused
    rst();
    for (int c = 8'h40; c <= 8'h44; c++) begin
      int_clear = 1;
      tick(1);
      int_clear = 0;
      cmd({rnd() % 2 == 1, c[6:0]});
      tick(1);
      chk("inv", 8'(interrupt_status_reg), 8'h04);
      chk("cmd_inv", command_reg, 8'h00);
    end
    // access fifo after parity abort, then after dma abort
    for (int pd = 0; pd < 2; pd++) begin
      rst();
      pair_drain_mode = pd[0];
      lv = '{5'(3 + rnd() % 14), 5'h02, 5'h01, 5'h00};
      fifo_count_field = lv[0];
      if (pd == 0) begin
        cmd(8'h2B);
        parity_err = 1;
        tick(1);
        parity_err = 0;
        tick(1);
        chk("cmd_par", command_reg, 8'h00);
      end else begin
        dma_abort_seen = 1;
        tick(1);
        dma_abort_seen = 0;
      end
      cmd(8'h85);
      foreach (lv[i]) begin
        fifo_count_field = lv[i];
        tick(2);
        chk("dma_request", 8'(dma_request), 8'(pd ? lv[i] >= 2 : lv[i] != 0));
      end
    end
    // select with atn and stop; host has set up timeout, ids and count
    connected = 0;
    phase = 3'h6;
    rst();
    cmd(8'hC3);
    chk("arb", 8'(arb_request), 8'h01);
    arb_won = 1;
    tick(1);
    arb_won = 0;
    chk("atn_sel", 8'(atn_out), 8'h01);
    sel_done = 1;
    tick(1);
    sel_done = 0;
    tick(1);
    chk("go", 8'(xfer_go), 8'h01);
    tx_byte_done = 1;
    tick(1);
    tx_byte_done = 0;
    chk("int_stop", 8'(interrupt_status_reg), 8'h01);
    chk("atn_held", 8'(atn_out), 8'h01);
    chk("seq", 8'(sequence_state_reg), 8'h03);
    cmd(8'h10);
    chk("atn_armed", 8'(atn_out), 8'h01);
    count_zero_flag = 1;
    tick(1);
    count_zero_flag = 0;
    chk("atn_drop", 8'(atn_out), 8'h00);
    // enable selection, lose it on disconnect, re-arm, then reselect timeout
    b = 8'(rnd());
    cmd({b[0], 7'h44});
    chk("sre", 8'({selresel_enable, rx_to_dma}), 8'({1'b1, b[0]}));
    bus_free = 1;
    tick(1);
    bus_free = 0;
    chk("sre_off", 8'(selresel_enable), 8'h00);
    cmd(8'h44);
    chk("sre_again", 8'(selresel_enable), 8'h01);
    tick(1);
    cmd(8'h40);
    chk("resel", 8'({arb_request, sequence_state_reg}), 8'h08);
    sel_timeout = 1;
    tick(1);
    sel_timeout = 0;
    chk("resel_to", 8'({interrupt_status_reg[3], arb_request}), 8'h02);
    // dma stop in an asynchronous receive with a full fifo
    rst();
    dma_xfer_active = 1;
    fifo_count_field = 5'h10;
    tick(1);
    chk("halt", 8'({dma_request, halted}), 8'h03);
    cmd(8'h84);
    chk("dstop", 8'({dma_request, dma_if_reset}), 8'h01);
    dma_xfer_active = 0;
    fifo_count_field = 5'h00;
    tick(1);
    chk("dstop_end", 8'({interrupt_status_reg, dma_if_reset}), 8'h02);
    test_done();
  end
endmodule : scs_sequencer_tb
`default_nettype wire
